// >>> include/hpc_pkg.sv
package hpc_pkg;

  localparam int REF_PERIOD_NS = 5;
  localparam int REF_HZ        = 200_000_000;

  // pin must stay high this long before a start is issued
  localparam int QUAL_TIME_US  = 100;
  localparam int QUAL_CYC      = (QUAL_TIME_US * 1000 + REF_PERIOD_NS - 1) / REF_PERIOD_NS;

  // one millisecond tick for repeat and loop gaps
  localparam int MS_TIME_US    = 1000;
  localparam int MS_CYC        = (MS_TIME_US * 1000) / REF_PERIOD_NS;

  localparam int WAVES         = 8;
  localparam int WIDX_W        = 3;
  localparam int NCO_W         = 28;

  localparam logic [NCO_W-1:0] NCO_MOD        = NCO_W'(REF_HZ);
  localparam logic [15:0]      DRIVE_HZ_RST   = 16'h00AA;
  localparam logic [15:0]      SWITCH_HZ_RST  = 16'h4E20;
  localparam logic [7:0]       COUNT_ZERO     = 8'h00;
  localparam logic [7:0]       COUNT_ONE      = 8'h01;

  typedef enum logic [3:0] {
    HPC_IDLE  = 4'h1,
    HPC_PULSE = 4'h2,
    HPC_RGAP  = 4'h4,
    HPC_LGAP  = 4'h8
  } hpc_state_t;

  // one stored waveform: pulse length, pulses per waveform, gap between pulses
  typedef struct packed {
    logic [7:0] pulse_ms;
    logic [7:0] repeat_count;
    logic [7:0] repeat_ms;
  } hpc_wave_t;

  // playback control byte, written by the host in a single data byte
  typedef struct packed {
    logic [1:0]        rsvd;
    logic              ack_reset;
    logic              halt_request_bit;
    logic              play_request_bit;
    logic [WIDX_W-1:0] effect_select_field;
  } hpc_ctrl_t;

  // device state byte, seen by the host
  typedef struct packed {
    logic [3:0] rsvd;
    logic       reset_indication;
    logic       thermal_fault_flag;
    logic       current_fault_flag;
    logic       playback_busy_flag;
  } hpc_status_t;

endpackage : hpc_pkg

// >>> verilog/hpc_sync3.sv
`timescale 1ns/1ps
module hpc_sync3 #(
  parameter int W = 1
) (
  input  wire logic         clk,
  input  wire logic         rst_n,
  input  wire logic         ce,
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);

  logic [W-1:0] s1_q;
  logic [W-1:0] s2_q;
  logic [W-1:0] s3_q;

  if (W < 1)
  begin : g_bad_w
    $error("hpc_sync3: W must be at least 1");
  end

  // a bit is taken only once stages two and three agree
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      s1_q <= '0;
      s2_q <= '0;
      s3_q <= '0;
      q    <= '0;
    end
    else if (ce)
    begin
      s1_q <= d;
      s2_q <= s1_q;
      s3_q <= s2_q;
      q    <= (s2_q & s3_q) | (q & (s2_q | s3_q));
    end
  end

endmodule : hpc_sync3

// >>> verilog/hpc_pin_qual.sv
`timescale 1ns/1ps
module hpc_pin_qual #(
  parameter int QUAL_CYC = hpc_pkg::QUAL_CYC
) (
  input  wire logic ref_clk,
  input  wire logic rst_n,
  input  wire logic ce,
  input  wire logic pin_trigger_input,
  input  wire logic pin_style_bit,
  input  wire logic busy,
  output logic      pin_start,
  output logic      pin_stop
);

  localparam int CW = $clog2(QUAL_CYC + 1);
  localparam logic [CW-1:0] QUAL_LAST = CW'(QUAL_CYC - 1);

  if (QUAL_CYC < 2)
  begin : g_bad_qual
    $error("hpc_pin_qual: QUAL_CYC must be at least 2");
  end

  logic          lvl;
  logic          lvl_prev_q;
  logic          armed_q;
  logic [CW-1:0] hi_cnt_q;
  wire           rise = lvl & ~lvl_prev_q;
  wire           fall = ~lvl & lvl_prev_q;
  wire           fire = armed_q & lvl & (hi_cnt_q == QUAL_LAST) & ~busy;

  hpc_sync3 #(
    .W (1)
  ) u_pin_sync (
    .clk   (ref_clk),
    .rst_n (rst_n),
    .ce    (ce),
    .d     (pin_trigger_input),
    .q     (lvl)
  );

  // high time counted on the master clock after synchronising
  always_ff @(posedge ref_clk)
  begin
    if (!rst_n)
    begin
      lvl_prev_q <= 1'b0;
      armed_q    <= 1'b0;
      hi_cnt_q   <= '0;
    end
    else if (ce)
    begin
      lvl_prev_q <= lvl;
      hi_cnt_q   <= rise ? '0 : (armed_q ? hi_cnt_q + CW'(1) : hi_cnt_q);
      // a rise that stops playback never arms a new start
      armed_q    <= rise ? ~busy : (armed_q & lvl & ~fire);
    end
  end

  // start follows qualification at once, far inside either power-state limit
  assign pin_start = fire;
  // edge style stops on a rise, level style on a fall; idle edges do nothing
  assign pin_stop  = busy & (pin_style_bit ? fall : rise);

endmodule : hpc_pin_qual

// >>> verilog/hpc_playback.sv
// Contract
// - play selected one of eight stored waveforms
// - busy flag set while any waveform runs
// - start requests ignored while busy
// - play request bit clears at every start
// - one byte selects and starts a waveform
// - halt stops at once, bit self-clears
// - style bit picks edge or level pin
// - qualified 100us high starts when idle
// - pin start begins within allowed delay
// - edge style: rise while busy stops
// - level style: fall while busy stops
// - without loop play waveform exactly once
// - loop replays with millisecond gap, zero allowed
// - loop keeps busy until a stop
// - each loop replays full pulse repeats
// - drive hz sets rate, autoresonance updates it
// - fault gate refuses start on fault flags
// - ungated start stops if fault persists
// - fault flags clear only on state read
// - reset indication blocks starts, not access
`timescale 1ns/1ps
module hpc_playback #(
  parameter int QUAL_CYC = hpc_pkg::QUAL_CYC,
  parameter int MS_CYC   = hpc_pkg::MS_CYC
) (
  input  wire logic                        ref_clk,
  input  wire logic                        rst_n,
  input  wire logic                        ce,
  input  wire logic                        link_clk,
  input  wire logic                        link_rst_n,
  input  wire logic                        host_ctrl_wr,
  input  wire hpc_pkg::hpc_ctrl_t          host_ctrl_data,
  input  wire logic                        host_state_rd,
  output hpc_pkg::hpc_status_t             host_state,
  input  wire logic                        pin_trigger_input,
  input  wire logic                        deep_sleep_state,
  input  wire logic                        pin_style_bit,
  input  wire logic                        loop_enable_bit,
  input  wire logic [7:0]                  loop_gap_ms,
  input  wire logic                        fault_gate_enable,
  input  wire logic                        current_fault_cond,
  input  wire logic                        thermal_fault_cond,
  input  wire logic                        wave_wr,
  input  wire logic [hpc_pkg::WIDX_W-1:0]  wave_idx,
  input  wire hpc_pkg::hpc_wave_t          wave_data,
  input  wire logic                        drive_hz_wr,
  input  wire logic [15:0]                 drive_hz_data,
  input  wire logic                        meas_valid,
  input  wire logic [15:0]                 meas_hz,
  input  wire logic                        switch_hz_wr,
  input  wire logic [15:0]                 switch_hz_data,
  output logic [15:0]                      resonant_drive_hz,
  output logic [15:0]                      switching_rate_hz,
  output logic                             playback_busy_flag,
  output logic                             play_request_bit,
  output logic                             halt_request_bit,
  output logic [hpc_pkg::WIDX_W-1:0]       active_effect,
  output logic                             drive_active,
  output logic                             drive_step
);

  localparam int PW = $clog2(MS_CYC);
  localparam logic [PW-1:0] MS_LAST = PW'(MS_CYC - 1);

  if (MS_CYC < 2)
  begin : g_bad_ms
    $error("hpc_playback: MS_CYC must be at least 2");
  end

  // link side: toggles mark each write and read, data held until next write
  logic               lk_wr_tog_q;
  logic               lk_rd_tog_q;
  hpc_pkg::hpc_ctrl_t lk_ctrl_q;

  always_ff @(posedge link_clk)
  begin
    if (!link_rst_n)
    begin
      lk_wr_tog_q <= 1'b0;
      lk_rd_tog_q <= 1'b0;
      lk_ctrl_q   <= '0;
    end
    else
    begin
      if (host_ctrl_wr)
      begin
        lk_wr_tog_q <= ~lk_wr_tog_q;
        lk_ctrl_q   <= host_ctrl_data;
      end
      if (host_state_rd)
      begin
        lk_rd_tog_q <= ~lk_rd_tog_q;
      end
    end
  end

  logic [1:0] tog_s;
  logic [1:0] tog_prev_q;

  hpc_sync3 #(
    .W (2)
  ) u_tog_sync (
    .clk   (ref_clk),
    .rst_n (rst_n),
    .ce    (ce),
    .d     ({lk_rd_tog_q, lk_wr_tog_q}),
    .q     (tog_s)
  );

  // ctrl data is stable long before its toggle lands here
  wire wr_ev      = tog_s[0] ^ tog_prev_q[0];
  wire rd_ev      = tog_s[1] ^ tog_prev_q[1];
  wire host_play  = wr_ev & lk_ctrl_q.play_request_bit;
  wire host_halt  = wr_ev & lk_ctrl_q.halt_request_bit;
  wire host_ack   = wr_ev & lk_ctrl_q.ack_reset;

  hpc_pkg::hpc_wave_t     wave_mem [hpc_pkg::WAVES];
  hpc_pkg::hpc_wave_t     wave_q;
  hpc_pkg::hpc_state_t    state_q;
  hpc_pkg::hpc_state_t    state_d;
  logic [hpc_pkg::WIDX_W-1:0] sel_q;
  logic                   play_req_q;
  logic                   halt_req_q;
  logic                   reset_ind_q;
  logic                   cur_f_q;
  logic                   therm_f_q;
  logic [PW-1:0]          presc_q;
  logic [7:0]             ms_left_q;
  logic [7:0]             ms_left_d;
  logic [7:0]             rep_left_q;
  logic [7:0]             rep_left_d;
  logic [hpc_pkg::NCO_W-1:0] nco_q;
  logic                   pin_start;
  logic                   pin_stop;

  wire busy      = (state_q != hpc_pkg::HPC_IDLE);
  wire any_fault = cur_f_q | therm_f_q;
  wire tick      = (presc_q == MS_LAST);
  wire seg_done  = (ms_left_q == hpc_pkg::COUNT_ZERO) |
                   (tick & (ms_left_q == hpc_pkg::COUNT_ONE));
  wire refuse    = reset_ind_q | (fault_gate_enable & any_fault);
  wire start_acc = (play_req_q | pin_start) & ~busy & ~refuse;
  // ungated playback is cut while the fault is still present
  wire fault_cut = busy & ~fault_gate_enable & (current_fault_cond | thermal_fault_cond);
  wire stop_req  = halt_req_q | pin_stop | fault_cut;
  wire last_rep  = (rep_left_q <= hpc_pkg::COUNT_ONE);

  hpc_pin_qual #(
    .QUAL_CYC (QUAL_CYC)
  ) u_pin (
    .ref_clk           (ref_clk),
    .rst_n             (rst_n),
    .ce                (ce),
    .pin_trigger_input (pin_trigger_input),
    .pin_style_bit     (pin_style_bit),
    .busy              (busy),
    .pin_start         (pin_start),
    .pin_stop          (pin_stop)
  );

  always_comb
  begin
    state_d    = state_q;
    ms_left_d  = ms_left_q;
    rep_left_d = rep_left_q;
    case (state_q)
      hpc_pkg::HPC_IDLE:
      begin
        if (start_acc)
        begin
          state_d    = hpc_pkg::HPC_PULSE;
          ms_left_d  = wave_mem[sel_q].pulse_ms;
          rep_left_d = wave_mem[sel_q].repeat_count;
        end
      end
      hpc_pkg::HPC_PULSE:
      begin
        if (seg_done && !last_rep)
        begin
          state_d    = hpc_pkg::HPC_RGAP;
          ms_left_d  = wave_q.repeat_ms;
          rep_left_d = rep_left_q - hpc_pkg::COUNT_ONE;
        end
        else if (seg_done && loop_enable_bit)
        begin
          state_d    = hpc_pkg::HPC_LGAP;
          ms_left_d  = loop_gap_ms;
        end
        else if (seg_done)
        begin
          state_d    = hpc_pkg::HPC_IDLE;
        end
      end
      hpc_pkg::HPC_RGAP:
      begin
        if (seg_done)
        begin
          state_d    = hpc_pkg::HPC_PULSE;
          ms_left_d  = wave_q.pulse_ms;
        end
      end
      hpc_pkg::HPC_LGAP:
      begin
        if (seg_done)
        begin
          state_d    = hpc_pkg::HPC_PULSE;
          ms_left_d  = wave_q.pulse_ms;
          rep_left_d = wave_q.repeat_count;
        end
      end
      default:
      begin
        state_d = hpc_pkg::HPC_IDLE;
      end
    endcase
    if (stop_req)
    begin
      state_d = hpc_pkg::HPC_IDLE;
    end
  end

  always_ff @(posedge ref_clk)
  begin
    if (wave_wr && ce)
    begin
      wave_mem[wave_idx] <= wave_data;
    end
  end

  always_ff @(posedge ref_clk)
  begin
    if (!rst_n)
    begin
      tog_prev_q  <= '0;
      state_q     <= hpc_pkg::HPC_IDLE;
      wave_q      <= '0;
      sel_q       <= '0;
      play_req_q  <= 1'b0;
      halt_req_q  <= 1'b0;
      reset_ind_q <= 1'b1;
      cur_f_q     <= 1'b0;
      therm_f_q   <= 1'b0;
      presc_q     <= '0;
      ms_left_q   <= '0;
      rep_left_q  <= '0;
    end
    else if (ce)
    begin
      tog_prev_q  <= tog_s;
      state_q     <= state_d;
      ms_left_q   <= (state_d != state_q || tick) && state_d == state_q ?
                     ms_left_q - hpc_pkg::COUNT_ONE : ms_left_d;
      rep_left_q  <= rep_left_d;
      presc_q     <= (state_d != state_q || tick) ? '0 : presc_q + PW'(1);
      wave_q      <= start_acc ? wave_mem[sel_q] : wave_q;
      sel_q       <= wr_ev ? lk_ctrl_q.effect_select_field : sel_q;
      // pending request lives one cycle: it starts or is dropped
      play_req_q  <= host_play & ~busy & ~play_req_q;
      halt_req_q  <= host_halt & ~halt_req_q;
      reset_ind_q <= reset_ind_q & ~host_ack;
      // a new fault wins over a clearing read in the same cycle
      cur_f_q     <= current_fault_cond | (cur_f_q & ~rd_ev);
      therm_f_q   <= thermal_fault_cond | (therm_f_q & ~rd_ev);
    end
  end

  // phase accumulator: one step per 1/hz second while driving
  wire [hpc_pkg::NCO_W-1:0] nco_sum  = nco_q + hpc_pkg::NCO_W'(resonant_drive_hz);
  wire                      nco_wrap = (nco_sum >= hpc_pkg::NCO_MOD);

  always_ff @(posedge ref_clk)
  begin
    if (!rst_n)
    begin
      nco_q             <= '0;
      drive_step        <= 1'b0;
      resonant_drive_hz <= hpc_pkg::DRIVE_HZ_RST;
      switching_rate_hz <= hpc_pkg::SWITCH_HZ_RST;
      active_effect     <= '0;
    end
    else if (ce)
    begin
      nco_q             <= !drive_active ? '0 : (nco_wrap ? nco_sum - hpc_pkg::NCO_MOD : nco_sum);
      drive_step        <= drive_active & nco_wrap;
      // autoresonance result overrides a host write in the same cycle
      resonant_drive_hz <= meas_valid ? meas_hz : (drive_hz_wr ? drive_hz_data : resonant_drive_hz);
      switching_rate_hz <= switch_hz_wr ? switch_hz_data : switching_rate_hz;
      active_effect     <= start_acc ? sel_q : active_effect;
    end
  end

  assign playback_busy_flag = busy;
  assign drive_active       = (state_q == hpc_pkg::HPC_PULSE);
  assign play_request_bit   = play_req_q;
  assign halt_request_bit   = halt_req_q;

  hpc_pkg::hpc_status_t st_word;
  assign st_word = '{rsvd: 4'h0, reset_indication: reset_ind_q, thermal_fault_flag: therm_f_q,
                     current_fault_flag: cur_f_q, playback_busy_flag: busy};

  hpc_sync3 #(
    .W ($bits(hpc_pkg::hpc_status_t))
  ) u_state_sync (
    .clk   (link_clk),
    .rst_n (link_rst_n),
    .ce    (1'b1),
    .d     (st_word),
    .q     (host_state)
  );

  a_start_needs_idle: assert property (
    @(posedge ref_clk) disable iff (!rst_n) ce && start_acc |-> !busy)
    else $error("start accepted while busy");

  a_play_self_clear: assert property (
    @(posedge ref_clk) disable iff (!rst_n) ce && play_req_q |=> !play_req_q)
    else $error("play request did not clear");

  a_halt_stops_now: assert property (
    @(posedge ref_clk) disable iff (!rst_n)
    ce && halt_req_q |=> state_q == hpc_pkg::HPC_IDLE && !halt_req_q)
    else $error("halt did not stop and clear");

  a_gate_refuses: assert property (
    @(posedge ref_clk) disable iff (!rst_n)
    ce && !busy && fault_gate_enable && any_fault |=> !busy)
    else $error("gated fault did not refuse start");

  a_reset_blocks: assert property (
    @(posedge ref_clk) disable iff (!rst_n) ce && reset_ind_q && !busy |=> !busy)
    else $error("start during reset indication");

  a_loop_stays_busy: assert property (
    @(posedge ref_clk) disable iff (!rst_n)
    ce && drive_active && seg_done && last_rep && loop_enable_bit && !stop_req
    |=> state_q == hpc_pkg::HPC_LGAP)
    else $error("loop mode left busy");

  a_single_shot: assert property (
    @(posedge ref_clk) disable iff (!rst_n)
    ce && drive_active && seg_done && last_rep && !loop_enable_bit |=> !busy)
    else $error("single play did not end");

  a_fault_read_clear: assert property (
    @(posedge ref_clk) disable iff (!rst_n) $fell(cur_f_q) |-> $past(rd_ev))
    else $error("fault flag cleared without read");

  a_effect_taken: assert property (
    @(posedge ref_clk) disable iff (!rst_n)
    ce && start_acc |=> active_effect == $past(sel_q) && drive_active)
    else $error("wrong effect started");

  a_pin_edge_stop: assert property (
    @(posedge ref_clk) disable iff (!rst_n)
    ce && busy && pin_stop && !pin_style_bit |=> !busy)
    else $error("edge stop ignored");

endmodule : hpc_playback

// >>> sim/hpc_host_model.sv
`timescale 1ns/1ps
module hpc_host_model (
  input  wire logic          link_clk,
  output logic               host_ctrl_wr,
  output hpc_pkg::hpc_ctrl_t host_ctrl_data,
  output logic               host_state_rd,
  output logic               pin_trigger_input
);
  initial
  begin
    host_ctrl_wr      = 1'b0;
    host_ctrl_data    = '0;
    host_state_rd     = 1'b0;
    pin_trigger_input = 1'b0;
  end

  // select and start travel in one control byte
  task automatic write_ctrl(input logic [2:0] eff, input logic play, halt, ack);
    @(negedge link_clk);
    host_ctrl_data = {2'h0, ack, halt, play, eff};
    host_ctrl_wr   = 1'b1;
    @(negedge link_clk);
    host_ctrl_wr   = 1'b0;
    // released byte is garbage, not a stale copy
    host_ctrl_data = ~host_ctrl_data;
  endtask : write_ctrl

  task automatic read_state();
    @(negedge link_clk);
    host_state_rd = 1'b1;
    @(negedge link_clk);
    host_state_rd = 1'b0;
  endtask : read_state

  // pin is low whenever the driver is not controlling playback
  task automatic pin_hold(input logic v, input int n);
    @(negedge link_clk);
    pin_trigger_input = v;
    repeat (n) @(negedge link_clk);
  endtask : pin_hold
endmodule : hpc_host_model

// >>> sim/hpc_playback_tb.sv
`timescale 1ns/1ps
`define CHK(g, e) \
  begin \
    tests_run++; \
    if ((g) !== (e)) \
    begin \
      fails++; \
      $display("wrong value at %0t: got %0h expected %0h", $time, g, e); \
    end \
  end
module hpc_playback_tb;
  localparam int QC = 20;
  localparam int MC = 10;
  logic ref_clk = 0, link_clk = 0, rst_n = 0, link_rst_n = 0, ce = 1;
  logic host_ctrl_wr, host_state_rd, pin_trigger_input, wave_wr = 0;
  logic pin_style_bit = 0, loop_enable_bit = 0, fault_gate_enable = 0;
  logic current_fault_cond = 0, thermal_fault_cond = 0, drive_hz_wr = 0;
  logic meas_valid = 0, switch_hz_wr = 0;
  logic [7:0]  loop_gap_ms = 8'h00;
  logic [2:0]  wave_idx = 3'h0, active_effect;
  logic [15:0] drive_hz_data = 16'h0000, meas_hz = 16'h0000, switch_hz_data = 16'h0000;
  logic [15:0] resonant_drive_hz, switching_rate_hz;
  logic        playback_busy_flag, play_request_bit, halt_request_bit, drive_active, drive_step;
  hpc_pkg::hpc_ctrl_t   host_ctrl_data;
  hpc_pkg::hpc_status_t host_state;
  hpc_pkg::hpc_wave_t   wave_data = '0;
  hpc_pkg::hpc_wave_t   wtab [8];
  int   fails = 0, tests_run = 0, run_len = 0, cur_len = -1, rises = 0;
  int   exp_len[$];
  logic [2:0] exp_eff[$];
  logic busy_d = 0, saw_req = 0, saw_halt = 0, act_d = 0, hit;

  initial forever #2.5 ref_clk = ~ref_clk;
  initial forever #7.5 link_clk = ~link_clk;

  hpc_playback #(.QUAL_CYC(QC), .MS_CYC(MC)) dut (
    .ref_clk(ref_clk), .rst_n(rst_n), .ce(ce), .link_clk(link_clk), .link_rst_n(link_rst_n),
    .host_ctrl_wr(host_ctrl_wr), .host_ctrl_data(host_ctrl_data),
    .host_state_rd(host_state_rd), .host_state(host_state),
    .pin_trigger_input(pin_trigger_input), .deep_sleep_state(1'b0),
    .pin_style_bit(pin_style_bit), .loop_enable_bit(loop_enable_bit),
    .loop_gap_ms(loop_gap_ms), .fault_gate_enable(fault_gate_enable),
    .current_fault_cond(current_fault_cond), .thermal_fault_cond(thermal_fault_cond),
    .wave_wr(wave_wr), .wave_idx(wave_idx), .wave_data(wave_data),
    .drive_hz_wr(drive_hz_wr), .drive_hz_data(drive_hz_data),
    .meas_valid(meas_valid), .meas_hz(meas_hz),
    .switch_hz_wr(switch_hz_wr), .switch_hz_data(switch_hz_data),
    .resonant_drive_hz(resonant_drive_hz), .switching_rate_hz(switching_rate_hz),
    .playback_busy_flag(playback_busy_flag), .play_request_bit(play_request_bit),
    .halt_request_bit(halt_request_bit), .active_effect(active_effect),
    .drive_active(drive_active), .drive_step(drive_step)
  );

  hpc_host_model u_host (
    .link_clk(link_clk), .host_ctrl_wr(host_ctrl_wr), .host_ctrl_data(host_ctrl_data),
    .host_state_rd(host_state_rd), .pin_trigger_input(pin_trigger_input)
  );

  // one note per expected start: effect and busy length (-1 = stopped early)
  // sampled mid-cycle, away from the edge that launches the outputs
  always @(negedge ref_clk)
  begin
    if (play_request_bit === 1'b1) saw_req = 1'b1;
    if (halt_request_bit === 1'b1) saw_halt = 1'b1;
    if (drive_active === 1'b1 && !act_d) rises++;
    act_d = (drive_active === 1'b1);
    if (playback_busy_flag === 1'b1 && !busy_d)
    begin
      `CHK(exp_eff.size() > 0, 1'b1)
      if (exp_eff.size() > 0)
      begin
        `CHK(active_effect, exp_eff.pop_front())
        cur_len = exp_len.pop_front();
      end
      run_len = 0;
    end
    if (playback_busy_flag === 1'b1) run_len++;
    if (playback_busy_flag !== 1'b1 && busy_d && cur_len >= 0)
      `CHK((run_len >= cur_len) && (run_len <= cur_len + 8), 1'b1)
    busy_d = (playback_busy_flag === 1'b1);
  end

  function automatic int wlen(input int e);
    return (wtab[e].repeat_count * wtab[e].pulse_ms + wtab[e].repeat_count - 1) * MC;
  endfunction : wlen

  task automatic host_wr(input int e, input logic p, h, a, input int len);
    if (len > -2)
    begin
      exp_eff.push_back(e[2:0]);
      exp_len.push_back(len);
    end
    u_host.write_ctrl(e[2:0], p, h, a);
    repeat (10) @(negedge ref_clk);
  endtask : host_wr

  task automatic wait_busy(input logic v, input int n, output logic got);
    got = 1'b0;
    for (int k = 0; k < n && !got; k++)
    begin
      @(negedge ref_clk);
      got = (playback_busy_flag === v);
    end
  endtask : wait_busy

  task automatic final_report();
    $display("checks %0d, mismatches %0d", tests_run, fails);
    if (fails == 0 && tests_run > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask : final_report

  initial
  begin
    #150_000;
    fails++;
    final_report();
  end

  initial
  begin
    void'($urandom(32'h2cbc3bdd));
    repeat (3) @(negedge ref_clk);
    rst_n = 1'b1;
    link_rst_n = 1'b1;
    `CHK(resonant_drive_hz, hpc_pkg::DRIVE_HZ_RST)
    `CHK(switching_rate_hz, hpc_pkg::SWITCH_HZ_RST)
    `CHK(playback_busy_flag, 1'b0)
    // waveform table is written only while idle
    for (int i = 0; i < 8; i++)
    begin
      wtab[i] = '{8'(1 + $urandom % 2), 8'(1 + i % 3), 8'h01};
      wave_idx = 3'(i);
      wave_data = wtab[i];
      wave_wr = 1'b1;
      @(negedge ref_clk);
      wave_wr = 1'b0;
    end
    host_wr(3, 1, 0, 0, -2);
    wait_busy(1, 20, hit);
    `CHK(hit, 1'b0)
    host_wr(0, 0, 0, 1, -2);
    for (int e = 0; e < 8; e++)
    begin
      host_wr(e, 1, 0, 0, wlen(e));
      if (e == 2) host_wr(5, 1, 0, 0, -2);
      wait_busy(0, 400, hit);
      `CHK(hit, 1'b1)
      wait_busy(1, 30, hit);
      `CHK(hit, 1'b0)
    end
    host_wr(1, 0, 1, 0, -2);
    `CHK(playback_busy_flag, 1'b0)
    loop_enable_bit = 1'b1;
    for (int g = 0; g < 2; g++)
    begin
      loop_gap_ms = 8'(g);
      host_wr(2, 1, 0, 0, -1);
      rises = 0;
      wait_busy(0, 2 * (wlen(2) + g * MC), hit);
      `CHK(hit, 1'b0)
      `CHK(rises >= 5, 1'b1)
      saw_halt = 1'b0;
      host_wr(2, 0, 1, 0, -2);
      `CHK(playback_busy_flag, 1'b0)
      `CHK(saw_halt, 1'b1)
    end
    exp_eff.push_back(3'h2);
    exp_len.push_back(-1);
    u_host.pin_hold(1, 12);
    `CHK(playback_busy_flag, 1'b1)
    u_host.pin_hold(0, 4);
    `CHK(playback_busy_flag, 1'b1)
    u_host.pin_hold(1, 12);
    `CHK(playback_busy_flag, 1'b0)
    u_host.pin_hold(0, 4);
    pin_style_bit = 1'b1;
    exp_eff.push_back(3'h2);
    exp_len.push_back(-1);
    u_host.pin_hold(1, 12);
    `CHK(playback_busy_flag, 1'b1)
    u_host.pin_hold(0, 1);
    wait_busy(0, 12, hit);
    `CHK(hit, 1'b1)
    loop_enable_bit = 1'b0;
    fault_gate_enable = 1'b1;
    thermal_fault_cond = 1'b1;
    repeat (2) @(negedge ref_clk);
    thermal_fault_cond = 1'b0;
    host_wr(4, 1, 0, 0, -2);
    `CHK(playback_busy_flag, 1'b0)
    repeat (10) @(negedge link_clk);
    `CHK(host_state.thermal_fault_flag, 1'b1)
    u_host.read_state();
    repeat (10) @(negedge link_clk);
    `CHK(host_state.thermal_fault_flag, 1'b0)
    host_wr(4, 1, 0, 0, wlen(4));
    wait_busy(0, 400, hit);
    fault_gate_enable = 1'b0;
    current_fault_cond = 1'b1;
    host_wr(6, 1, 0, 0, -1);
    `CHK(playback_busy_flag, 1'b0)
    current_fault_cond = 1'b0;
    u_host.read_state();
    drive_hz_data = 16'($urandom);
    drive_hz_wr = 1'b1;
    @(negedge ref_clk);
    drive_hz_wr = 1'b0;
    @(negedge ref_clk);
    `CHK(resonant_drive_hz, drive_hz_data)
    meas_hz = 16'($urandom);
    meas_valid = 1'b1;
    switch_hz_data = 16'h4E20;
    switch_hz_wr = 1'b1;
    @(negedge ref_clk);
    meas_valid = 1'b0;
    switch_hz_wr = 1'b0;
    @(negedge ref_clk);
    `CHK(resonant_drive_hz, meas_hz)
    `CHK(switching_rate_hz, 16'h4E20)
    repeat (20) @(negedge ref_clk);
    `CHK(exp_eff.size(), 0)
    final_report();
  end
endmodule : hpc_playback_tb
